/* File: design/gcp_pkg.sv */
// Purpose: Shared constants and types of the pin configuration block
// Assumes: 125 MHz system clock, 12-bit register byte address
// Notes:   The config register layout is carried as a packed struct
package gcp_pkg;

	localparam int PINS   = 12;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int EV_PINS = 2;
	localparam int EV_LSB  = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] CFG_OFFSET     = 12'h1E0;
	localparam logic [ADDR_W-1:0] DIRDATA_OFFSET = 12'h1E4;
	localparam logic [ADDR_W-1:0] STAT_OFFSET    = 12'h1F0;
	localparam logic [ADDR_W-1:0] MASK_OFFSET    = 12'h1F4;

	// Field positions
	localparam int DIR_LSB      = 16;
	localparam int DATA_LSB     = 0;
	localparam int STAT_CAP_LSB = 12;
	localparam int STAT_TMR_BIT = 14;
	localparam int STAT_W       = 15;

	// Reset values
	localparam logic [DATA_W-1:0] CFG_RESET  = 32'h0000_3000;
	localparam logic [PINS-1:0]   DIR_RESET  = 12'h000;
	localparam logic [PINS-1:0]   DATA_RESET = 12'h000;
	localparam logic [STAT_W-1:0] STAT_RESET = 15'h0000;
	localparam logic [STAT_W-1:0] MASK_RESET = 15'h0000;

	// Timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam int CLR_MIN_NS    = 40;
	localparam int CLR_CYCLES    =
		(CLR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// The agreement stage of the synchroniser can eat one sample
	localparam int CLR_HOLD = CLR_CYCLES - 1;
	localparam int CAP_HOLD = 1;

	typedef struct packed
	{
		logic [1:0]      reserved;
		logic [1:0]      timerClearEnable;
		logic [PINS-1:0] pinIrqPolarity;
		logic [1:0]      compareOutEnable;
		logic            pin9EventPolarity;
		logic            pin8EventPolarity;
		logic [PINS-1:0] pinBufferType;
	} gcp_cfg_type;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} gcp_bus_req_type;

endpackage : gcp_pkg

/* File: design/gcp_pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module gcp_pin_sync #(
	parameter int W = 12
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] asyncIn,
	output var  logic [W-1:0] stable
);
	import gcp_pkg::*;

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_stable;

	always_comb
	begin
		next_stable = stable;
		for (int i = 0; i < W; i++)
		begin
			if (s2[i] == s3[i])
			begin
				next_stable[i] = s3[i];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s1     <= '0;
			s2     <= '0;
			s3     <= '0;
			stable <= '0;
		end
		else
		begin
			s1     <= asyncIn;
			s2     <= s1;
			s3     <= s2;
			stable <= next_stable;
		end
	end

endmodule : gcp_pin_sync
`default_nettype wire

/* File: design/gcp_hold_edge.sv */
// Purpose: One pulse per active period once held for HOLD samples
// Assumes: Inputs already synchronous to clk
// Notes:   Counter saturates, so a long level gives a single pulse
`timescale 1ns/1ps
`default_nettype none
module gcp_hold_edge #(
	parameter int W    = 2,
	parameter int HOLD = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] active,
	input  wire logic [W-1:0] enable,
	output var  logic [W-1:0] pulse
);
	import gcp_pkg::*;

	localparam int CNT_W = $clog2(HOLD + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD - 1);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(HOLD);

	logic [CNT_W-1:0] cnt [W];
	logic [CNT_W-1:0] next_cnt [W];
	logic [W-1:0]     next_pulse;

	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			next_cnt[i]   = '0;
			next_pulse[i] = 1'b0;
			if (enable[i] && active[i])
			begin
				next_pulse[i] = (cnt[i] == LAST);
				next_cnt[i]   = (cnt[i] == FULL) ? cnt[i] : cnt[i] + 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pulse <= '0;
			for (int i = 0; i < W; i++)
			begin
				cnt[i] <= '0;
			end
		end
		else
		begin
			pulse <= next_pulse;
			for (int i = 0; i < W; i++)
			begin
				cnt[i] <= next_cnt[i];
			end
		end
	end

endmodule : gcp_hold_edge
`default_nettype wire

/* File: design/gcp_top.sv */
// Purpose: Pin configuration, level interrupts and timestamp pin functions
// Assumes: Single 125 MHz clock, synchronous active-low reset
// Notes:   Pins 9 and 8 carry compare outputs and capture/clear inputs
//
// Behaviour
// - Enabled pin event clears timer interrupt flag
// - Clear input polarity from pin polarity bits
// - Clear function only while pin is input
// - Clear inputs edge triggered, held over 40ns; logic acts once the level is seen for 4 samples (32 ns)
// - Pin at selected level sets status flag
// - Polarity bits select capture level, pins 9/8
// - Output enable drives compare events on pins
// - Compare enable forces output, buffer type kept
// - Bit 13 sets pin 9 event level
// - Bit 12 sets pin 8 event level
// - Enables and pin polarity fields reset to zero, event polarity bits 13:12 to one
// - Bits 11:0 select open-drain or push-pull
`timescale 1ns/1ps
`default_nettype none
module gcp_top (
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire gcp_pkg::gcp_bus_req_type            busReq,
	output var  logic [gcp_pkg::DATA_W-1:0]          rdData,
	input  wire logic [gcp_pkg::PINS-1:0]            pinIn,
	output var  logic [gcp_pkg::PINS-1:0]            pinOut,
	output var  logic [gcp_pkg::PINS-1:0]            pinOe,
	input  wire logic [gcp_pkg::EV_PINS-1:0]         compareEvent,
	input  wire logic                                timerIrqSet,
	output var  logic [gcp_pkg::EV_PINS-1:0]         captureStrobe,
	output var  logic                                timerIrqFlag,
	output var  logic                                irq
);
	import gcp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	gcp_cfg_type       cfg;
	gcp_cfg_type       next_cfg;
	logic [PINS-1:0]   dirReg;
	logic [PINS-1:0]   next_dirReg;
	logic [PINS-1:0]   dataReg;
	logic [PINS-1:0]   next_dataReg;
	logic [STAT_W-1:0] status;
	logic [STAT_W-1:0] next_status;
	logic [STAT_W-1:0] mask;
	logic [STAT_W-1:0] next_mask;
	logic [DATA_W-1:0] next_rdData;
	logic [PINS-1:0]   next_pinOut;
	logic [PINS-1:0]   next_pinOe;
	logic              next_irq;

	logic [PINS-1:0]    pinSync;
	logic [PINS-1:0]    pinActive;
	logic [PINS-1:0]    pinIsOut;
	logic [PINS-1:0]    pinValue;
	logic [EV_PINS-1:0] evActive;
	logic [EV_PINS-1:0] evIsIn;
	logic [EV_PINS-1:0] clrPulse;
	logic [STAT_W-1:0]  w1c;

	function automatic logic hit(input gcp_bus_req_type r,
		input logic [ADDR_W-1:0] a);
		return r.addr == a;
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	// Pin inputs and event qualification
	gcp_pin_sync #(.W(PINS)) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (pinIn),
		.stable  (pinSync)
	);

	// Same polarity bits serve level irq, capture and clear
	assign pinActive = ~(pinSync ^ cfg.pinIrqPolarity);
	assign evActive  = pinActive[EV_LSB +: EV_PINS];
	assign evIsIn    = ~pinIsOut[EV_LSB +: EV_PINS];

	// Held-level qualifier filters levels seen for fewer than CLR_HOLD (4) samples, one under the 40 ns minimum
	gcp_hold_edge #(.W(EV_PINS), .HOLD(CLR_HOLD)) u_clear (
		.clk    (clk),
		.rst_n  (rst_n),
		.active (evActive),
		.enable (cfg.timerClearEnable & evIsIn),
		.pulse  (clrPulse)
	);

	gcp_hold_edge #(.W(EV_PINS), .HOLD(CAP_HOLD)) u_capture (
		.clk    (clk),
		.rst_n  (rst_n),
		.active (evActive),
		.enable (evIsIn),
		.pulse  (captureStrobe)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin drive
	always_comb
	begin
		pinIsOut = dirReg;
		pinValue = dataReg;
		for (int i = 0; i < EV_PINS; i++)
		begin
			if (cfg.compareOutEnable[i])
			begin
				pinIsOut[EV_LSB + i] = 1'b1;
				pinValue[EV_LSB + i] = ~(compareEvent[i] ^ (i == 1 ?
					cfg.pin9EventPolarity : cfg.pin8EventPolarity));
			end
		end
		// Open-drain only pulls low; the pin floats for a one
		for (int i = 0; i < PINS; i++)
		begin
			if (cfg.pinBufferType[i])
			begin
				next_pinOut[i] = pinValue[i];
				next_pinOe[i]  = pinIsOut[i];
			end
			else
			begin
				next_pinOut[i] = 1'b0;
				next_pinOe[i]  = pinIsOut[i] & ~pinValue[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_comb
	begin
		next_cfg     = cfg;
		next_dirReg  = dirReg;
		next_dataReg = dataReg;
		next_mask    = mask;
		w1c          = '0;
		next_rdData  = '0;
		if (busReq.wr)
		begin
			if (hit(busReq, CFG_OFFSET))
			begin
				next_cfg          = gcp_cfg_type'(busReq.wdata);
				next_cfg.reserved = 2'h0;
			end
			if (hit(busReq, DIRDATA_OFFSET))
			begin
				next_dirReg  = busReq.wdata[DIR_LSB +: PINS];
				next_dataReg = busReq.wdata[DATA_LSB +: PINS];
			end
			if (hit(busReq, STAT_OFFSET))
			begin
				w1c = busReq.wdata[STAT_W-1:0];
			end
			if (hit(busReq, MASK_OFFSET))
			begin
				next_mask = busReq.wdata[STAT_W-1:0];
			end
		end
		if (busReq.rd)
		begin
			if (hit(busReq, CFG_OFFSET))
			begin
				next_rdData = cfg;
			end
			if (hit(busReq, DIRDATA_OFFSET))
			begin
				next_rdData[DIR_LSB +: PINS]  = dirReg;
				next_rdData[DATA_LSB +: PINS] =
					(pinIsOut & dataReg) | (~pinIsOut & pinSync);
			end
			if (hit(busReq, STAT_OFFSET))
			begin
				next_rdData[STAT_W-1:0] = status;
			end
			if (hit(busReq, MASK_OFFSET))
			begin
				next_rdData[STAT_W-1:0] = mask;
			end
		end
		// Sources set after the clear, so a same-cycle event survives
		next_status = status & ~w1c;
		next_status[PINS-1:0] = next_status[PINS-1:0] | pinActive;
		next_status[STAT_CAP_LSB +: EV_PINS] =
			next_status[STAT_CAP_LSB +: EV_PINS] | captureStrobe;
		if (|clrPulse)
		begin
			next_status[STAT_TMR_BIT] = 1'b0;
		end
		if (timerIrqSet)
		begin
			next_status[STAT_TMR_BIT] = 1'b1;
		end
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg     <= gcp_cfg_type'(CFG_RESET);
			dirReg  <= DIR_RESET;
			dataReg <= DATA_RESET;
			status  <= STAT_RESET;
			mask    <= MASK_RESET;
			rdData  <= '0;
			pinOut  <= '0;
			pinOe   <= '0;
			irq     <= 1'b0;
		end
		else
		begin
			cfg     <= next_cfg;
			dirReg  <= next_dirReg;
			dataReg <= next_dataReg;
			status  <= next_status;
			mask    <= next_mask;
			rdData  <= next_rdData;
			pinOut  <= next_pinOut;
			pinOe   <= next_pinOe;
			irq     <= next_irq;
		end
	end

	assign timerIrqFlag = status[STAT_TMR_BIT];

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_cfg_reset_value: assert property ($rose(rst_n) |-> cfg == CFG_RESET)
		else $error("config not at reset value");
	a_rsvd_read_zero: assert property (busReq.rd && hit(busReq, CFG_OFFSET)
		|=> rdData[31:30] == 2'h0 && rdData[29:0] == $past(cfg[29:0]))
		else $error("config read back wrong");
	a_timer_clear_pin: assert property (|clrPulse && !timerIrqSet
		|=> !timerIrqFlag)
		else $error("timer flag not cleared by pin");
	a_clear_needs_input: assert property (clrPulse[1]
		|-> $past(cfg.timerClearEnable[1]) && !$past(pinIsOut[9]))
		else $error("clear from disabled or output pin");
	a_clear_held_level: assert property (clrPulse[0]
		|-> $past(evActive[0]) && $past(evActive[0], 4))
		else $error("clear without held active level");
	a_clear_pol_match: assert property (clrPulse[1]
		|-> $past(pinSync[9]) == $past(cfg.pinIrqPolarity[9]))
		else $error("clear at wrong polarity");
	a_level_sets_status: assert property (1'b1 |=>
		(status[PINS-1:0] & $past(pinActive)) == $past(pinActive))
		else $error("level did not set status");
	a_capture_level: assert property (captureStrobe[0]
		|-> $past(evActive[0]) && $past(evIsIn[0]))
		else $error("capture at wrong level");
	a_event_drive_9: assert property (cfg.compareOutEnable[1]
		&& cfg.pinBufferType[9] |=> pinOe[9])
		else $error("compare output not driven");
	a_event_pol_9: assert property (cfg.compareOutEnable[1]
		&& cfg.pinBufferType[9] && compareEvent[1]
		|=> pinOut[9] == $past(cfg.pin9EventPolarity))
		else $error("pin 9 event level wrong");
	a_event_pol_8: assert property (cfg.compareOutEnable[0]
		&& cfg.pinBufferType[8] && !compareEvent[0]
		|=> pinOut[8] == !$past(cfg.pin8EventPolarity))
		else $error("pin 8 idle level wrong");
	a_open_drain: assert property (!cfg.pinBufferType[8]
		&& cfg.compareOutEnable[0] |=> !pinOut[8])
		else $error("open-drain pin driven high");
	// Clear, capture and compare-drive guards above repeated for the other event pin; pin 9 adds width and off checks
	a_clear_input_8: assert property (clrPulse[0]
		|-> $past(cfg.timerClearEnable[0]) && !$past(pinIsOut[8]))
		else $error("clear from disabled or output pin 8");
	a_clear_pol_8: assert property (clrPulse[0]
		|-> $past(pinSync[8]) == $past(cfg.pinIrqPolarity[8]))
		else $error("pin 8 clear at wrong polarity");
	a_clear_held_9: assert property (clrPulse[1]
		|-> $past(evActive[1]) && $past(evActive[1], 4))
		else $error("pin 9 clear without held level");
	a_capture_input_9: assert property (captureStrobe[1]
		|-> $past(evActive[1]) && $past(evIsIn[1]))
		else $error("pin 9 capture at wrong level");
	a_capture_single_9: assert property (captureStrobe[1]
		|=> !captureStrobe[1])
		else $error("pin 9 capture longer than one cycle");
	a_event_drive_8: assert property (cfg.compareOutEnable[0]
		&& cfg.pinBufferType[8] |=> pinOe[8])
		else $error("pin 8 compare output not driven");
	a_event_off_9: assert property (!cfg.compareOutEnable[1]
		&& !dirReg[9] |=> !pinOe[9])
		else $error("pin 9 driven with output disabled");
	// Set has priority over both ways of clearing the timer flag
	a_timer_set_wins: assert property (timerIrqSet |=> timerIrqFlag)
		else $error("timer flag set lost");
	a_w1c_timer: assert property (busReq.wr && hit(busReq, STAT_OFFSET)
		&& busReq.wdata[STAT_TMR_BIT] && !timerIrqSet |=> !timerIrqFlag)
		else $error("timer flag not cleared by write");
	a_rdata_idle: assert property (!busReq.rd |=> rdData == '0)
		else $error("read data not zero when idle");

	c_timer_clear: cover property (timerIrqFlag ##1 |clrPulse);
	c_capture: cover property (|captureStrobe);
	c_irq_raise: cover property (!irq ##1 irq);
	c_event_out: cover property (cfg.compareOutEnable[1] && compareEvent[1]);

endmodule : gcp_top
`default_nettype wire

/* File: verif/gcp_pin_partner.sv */
// Purpose: Board-side circuitry on the general purpose pins
// Assumes: Every pin carries a pull-up on the board
// Notes:   Device drive wins when both sides drive a pin
`timescale 1ns/1ps
`default_nettype none
module gcp_pin_partner (
	input  wire logic [gcp_pkg::PINS-1:0] pinOut,
	input  wire logic [gcp_pkg::PINS-1:0] pinOe,
	input  wire logic [gcp_pkg::PINS-1:0] extEn,
	input  wire logic [gcp_pkg::PINS-1:0] extVal,
	output var  logic [gcp_pkg::PINS-1:0] pinIn
);
	import gcp_pkg::*;
	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		for (int k = 0; k < PINS; k++)
		begin
			// Released line goes to the pull-up, never a stale value
			if (pinOe[k])
				pinIn[k] = pinOut[k];
			else if (extEn[k])
				pinIn[k] = extVal[k];
			else
				pinIn[k] = 1'b1;
		end
	end
endmodule : gcp_pin_partner
`default_nettype wire

/* File: verif/gcp_top_bench.sv */
// Purpose: Self-checking bench of the pin configuration block
// Assumes: Partner model resolves the pin wires
// Notes:   Waits cover the pin synchroniser delay with margin
`timescale 1ns/1ps
`default_nettype none
module gcp_top_bench;
	import gcp_pkg::*;
	logic                 clk          = 1'b0;
	logic                 rst_n        = 1'b0;
	gcp_bus_req_type      busReq       = '0;
	logic [DATA_W-1:0]    rdData;
	logic [PINS-1:0]      pinIn;
	logic [PINS-1:0]      pinOut;
	logic [PINS-1:0]      pinOe;
	logic [PINS-1:0]      extEn        = '0;
	logic [PINS-1:0]      extVal       = '0;
	logic [EV_PINS-1:0]   compareEvent = 2'h0;
	logic                 timerIrqSet  = 1'b0;
	logic [EV_PINS-1:0]   captureStrobe;
	logic                 timerIrqFlag;
	logic                 irq;
	logic [DATA_W-1:0]    rv;
	int                   errTotal     = 0;
	int                   nCompared    = 0;
	int                   cyc          = 0;
	////////////////////////////////////////////////////////////////////////
	always #4 clk = ~clk;

	gcp_top dut_u (
		.clk(clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.compareEvent(compareEvent), .timerIrqSet(timerIrqSet),
		.captureStrobe(captureStrobe), .timerIrqFlag(timerIrqFlag),
		.irq(irq)
	);

	gcp_pin_partner partner_u (
		.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extVal(extVal),
		.pinIn(pinIn)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	// Hang guard, far above the few hundred cycles used
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errTotal++;
			results();
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic wr_reg(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge clk);
		busReq.addr  <= a;
		busReq.wdata <= d;
		busReq.wr    <= 1'b1;
		@(posedge clk);
		busReq.wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [ADDR_W-1:0] a,
		output logic [DATA_W-1:0] d);
		@(posedge clk);
		busReq.addr <= a;
		busReq.rd   <= 1'b1;
		@(posedge clk);
		busReq.rd   <= 1'b0;
		#1;
		d = rdData;
	endtask : rd_reg
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd_reg(CFG_OFFSET, rv);
		check("cfg reset", rv, 32'h0000_3000);
		rd_reg(12'h1EC, rv);
		check("unmapped read", rv, 32'h0000_0000);
		wr_reg(CFG_OFFSET, 32'hFFFF_FFFF);
		rd_reg(CFG_OFFSET, rv);
		check("cfg reserved", rv, 32'h3FFF_FFFF);
		$display("test reset done");
	endtask : t_reset

	// Pin 9 active high, pin 8 active low, both buffer kinds
	task automatic t_compare;
		logic [1:0] lvl;
		for (int b = 0; b < 2; b++)
		begin
			wr_reg(CFG_OFFSET, b ? 32'h0000_E300 : 32'h0000_E000);
			for (int e = 0; e < 4; e++)
			begin
				compareEvent <= e[1:0];
				tick(4);
				#1;
				lvl = {e[1], ~e[0]};
				check("cmp oe", pinOe[9:8], b ? 2'h3 : 2'(~lvl));
				check("cmp out", pinOut[9:8], b ? lvl : 2'h0);
				@(posedge clk);
			end
		end
		compareEvent <= 2'h0;
		$display("test compare done");
	endtask : t_compare

	task automatic t_level;
		wr_reg(CFG_OFFSET, 32'h0008_3000);
		extEn[3]  <= 1'b1;
		extVal[3] <= 1'b1;
		tick(10);
		wr_reg(STAT_OFFSET, 32'h0000_7FFF);
		tick(2);
		rd_reg(STAT_OFFSET, rv);
		check("level status", rv, 32'h0000_0008);
		wr_reg(MASK_OFFSET, 32'h0000_0008);
		tick(3);
		#1;
		check("irq on", irq, 1'b1);
		@(posedge clk);
		extVal[3] <= 1'b0;
		tick(10);
		wr_reg(STAT_OFFSET, 32'h0000_0008);
		tick(3);
		#1;
		check("irq off", irq, 1'b0);
		rd_reg(STAT_OFFSET, rv);
		check("status cleared", rv, 32'h0000_0000);
		$display("test level done");
	endtask : t_level

	task automatic t_clear(input logic pol, input logic en,
		input logic dirOut, input logic expFlag);
		int caps;
		caps = 0;
		wr_reg(CFG_OFFSET, {2'h0, en, 3'h0, pol, 9'h0, 16'h3000});
		// Output at one: open-drain lets go, so the board level reaches it
		wr_reg(DIRDATA_OFFSET, {6'h0, dirOut, 15'h0, dirOut, 9'h0});
		extEn[9]  <= 1'b1;
		extVal[9] <= ~pol;
		tick(8);
		timerIrqSet <= 1'b1;
		tick(1);
		timerIrqSet <= 1'b0;
		tick(2);
		#1;
		check("flag set", timerIrqFlag, 1'b1);
		@(posedge clk);
		// Held 48 ns, above the minimum; capture pulses during the hold while pin 9 is an input
		extVal[9] <= pol;
		for (int k = 0; k < 21; k++)
		begin
			@(posedge clk);
			if (k == 5)
				extVal[9] <= ~pol;
			#1;
			if (captureStrobe[1] === 1'b1)
				caps++;
		end
		check("timer flag", timerIrqFlag, expFlag);
		check("captures", caps, {31'h0, ~dirOut});
		$display("test clear done");
	endtask : t_clear
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		tick(8);
		rst_n <= 1'b1;
		t_reset();
		t_compare();
		t_level();
		t_clear(1'b1, 1'b1, 1'b0, 1'b0);
		t_clear(1'b0, 1'b1, 1'b0, 1'b0);
		t_clear(1'b1, 1'b0, 1'b0, 1'b1);
		t_clear(1'b1, 1'b1, 1'b1, 1'b1);
		results();
	end
endmodule : gcp_top_bench
`default_nettype wire
